// ===== design/acs_sequencer.sv
// Converter mode, trigger and timing sequencer with its APB register file.
// Assumes APB master on pclk; analog front-end returns conv_data when asked.
`timescale 1ns/1ns
module acs_sequencer
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer trigger events, one-cycle pulses
    input  wire logic        pwm_match_a_zero,
    input  wire logic        pwm_underflow_one,
    // Analog front-end
    input  wire logic [9:0]  conv_data,
    output logic      [3:0]  ad_channel,
    output logic             ad_busy,
    output logic             ad_sample_hold,
    output logic             ad_bits10,
    output logic             ad_ref_connect,
    // Completion request level
    output logic             int_request
);

    typedef struct packed {
        acs_pkg::acs_state_type state;
        logic                   busy;
        logic [7:0]             first;
        logic [7:0]             second;
        logic [7:0]             third;
        logic [9:0]             result;
        logic                   pending;
        logic                   undef;
        logic [3:0]             channel;
        logic [2:0]             div_cnt;
        logic [5:0]             phi_cnt;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } acs_regs_type;

    acs_regs_type s;
    acs_regs_type next_s;

    // Channel code plus group to input index; bit 4 flags a legal pair
    function automatic logic [4:0] chan_decode(input logic [2:0] code, input logic grp);
        logic [4:0] r;
        r = {1'b1, 1'b0, code};
        if (grp)
        begin
            r = {code[2], 2'b10, code[1:0]};
        end
        return r;
    endfunction

    // Conversion length from timing option and resolution
    function automatic logic [5:0] conv_len(input logic sh, input logic b10);
        logic [5:0] r;
        if (sh)
        begin
            r = b10 ? acs_pkg::CYC_SH_10 : acs_pkg::CYC_SH_8;
        end
        else
        begin
            r = b10 ? acs_pkg::CYC_PLAIN_10 : acs_pkg::CYC_PLAIN_8;
        end
        return r;
    endfunction

    logic       acc;
    logic       wr_fire;
    logic       phi_en;
    logic       done;
    logic       trig;
    logic       hit;
    logic [2:0] div_mask;
    logic [4:0] sel;
    logic [5:0] target;

    // Bus phase decode; write lands on the edge that sees pready high
    assign acc     = psel && penable;
    assign wr_fire = acc && s.pready && pwrite;
    assign trig    = pwm_match_a_zero || pwm_underflow_one;
    assign sel     = chan_decode(s.first[acs_pkg::CH_MSB:acs_pkg::CH_LSB],
                                 s.third[acs_pkg::GROUP_BIT]);
    assign target  = conv_len(s.third[acs_pkg::SH_BIT], s.second[acs_pkg::BITS10_BIT]);

    // Converter clock enable: divide pclk by 1, 2, 4 or 8
    always_comb
    begin
        case (s.first[acs_pkg::DIV_MSB:acs_pkg::DIV_LSB])
            2'h0:    div_mask = 3'h0;
            2'h1:    div_mask = 3'h1;
            2'h2:    div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    end
    assign phi_en = (s.div_cnt & div_mask) == div_mask;
    assign done   = s.busy && phi_en && (s.phi_cnt == target - 6'd1);

    // Address hit for mapped registers
    assign hit = (paddr == acs_pkg::OFS_CONTROL_FIRST) || (paddr == acs_pkg::OFS_CONTROL_SECOND)
              || (paddr == acs_pkg::OFS_CONTROL_THIRD) || (paddr == acs_pkg::OFS_RESULT)
              || (paddr == acs_pkg::OFS_INT_CONTROL);

    // Next-state logic: progress, then bus write, then start, then flag set
    always_comb
    begin
        logic [4:0] pick; // Input index of the pair standing after this edge
        pick           = 5'h00;
        next_s         = s;
        next_s.div_cnt = s.div_cnt + 3'h1;
        // Conversion progress and completion
        // Repeat mode keeps busy high and rearms the counter at once
        if (s.busy && phi_en)
        begin
            next_s.phi_cnt = s.phi_cnt + 6'd1;
        end
        if (done)
        begin
            next_s.result  = conv_data;
            next_s.phi_cnt = 6'd0;
            if (!s.first[acs_pkg::MODE_BIT])
            begin
                next_s.state = acs_pkg::ACS_IDLE;
                next_s.busy  = 1'b0;
                if (!s.first[acs_pkg::TRIG_SEL_BIT])
                begin
                    next_s.first[acs_pkg::START_BIT] = 1'b0;
                end
            end
        end
        // APB handshake: one wait state, answer registered
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;
        if (acc && !s.pready)
        begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !hit;
            if (pwrite || !hit)
            begin
                next_s.prdata = 32'h0000_0000;
            end
            else if (paddr == acs_pkg::OFS_CONTROL_FIRST)
            begin
                next_s.prdata = {24'h00_0000, s.first};
            end
            else if (paddr == acs_pkg::OFS_CONTROL_SECOND)
            begin
                next_s.prdata = {24'h00_0000, s.second};
            end
            else if (paddr == acs_pkg::OFS_CONTROL_THIRD)
            begin
                next_s.prdata = {24'h00_0000, s.third};
            end
            else if (paddr == acs_pkg::OFS_RESULT)
            begin
                next_s.prdata = {22'h0, s.result};
            end
            else
            begin
                next_s.prdata = {30'h0, s.undef, s.pending};
            end
        end
        // Register writes
        // A first-register write mid-conversion poisons the result; it keeps running only if the write leaves start high
        if (wr_fire)
        begin
            if (paddr == acs_pkg::OFS_CONTROL_FIRST)
            begin
                next_s.first = pwdata[7:0];
                if (s.busy)
                begin
                    next_s.undef = 1'b1;
                    if (!pwdata[acs_pkg::START_BIT])
                    begin
                        next_s.state   = acs_pkg::ACS_IDLE;
                        next_s.busy    = 1'b0;
                        next_s.phi_cnt = 6'd0;
                    end
                end
            end
            else if (paddr == acs_pkg::OFS_CONTROL_SECOND)
            begin
                next_s.second = {6'h00, pwdata[1:0]};
            end
            else if (paddr == acs_pkg::OFS_CONTROL_THIRD)
            begin
                next_s.third = {6'h00, pwdata[1:0]};
            end
            else if (paddr == acs_pkg::OFS_INT_CONTROL)
            begin
                if (!pwdata[acs_pkg::PEND_BIT])
                begin
                    next_s.pending = 1'b0;
                end
            end
        end
        // Start: refused and cleared for a prohibited channel pair
        if (!next_s.busy && next_s.first[acs_pkg::START_BIT])
        begin
            // The write that sets start also sets code: decode what lands with the stored group
            pick = chan_decode(next_s.first[acs_pkg::CH_MSB:acs_pkg::CH_LSB],
                               next_s.third[acs_pkg::GROUP_BIT]);
            if (!pick[4])
            begin
                next_s.first[acs_pkg::START_BIT] = 1'b0;
            end
            else if (!next_s.first[acs_pkg::TRIG_SEL_BIT] || trig)
            begin
                next_s.state   = acs_pkg::ACS_CONV;
                next_s.busy    = 1'b1;
                next_s.phi_cnt = 6'd0;
                next_s.undef   = 1'b0;
                next_s.channel = pick[3:0];
            end
        end
        // Completion request, one-shot only; set wins over a clear
        if (done && !s.first[acs_pkg::MODE_BIT])
        begin
            next_s.pending = 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s         <= '0;
            s.state   <= acs_pkg::ACS_IDLE;
            s.first   <= acs_pkg::RST_CONTROL_FIRST;
            s.second  <= acs_pkg::RST_CONTROL_SECOND;
            s.third   <= acs_pkg::RST_CONTROL_THIRD;
            s.result  <= acs_pkg::RST_RESULT;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign prdata         = s.prdata;
    assign pready         = s.pready;
    assign pslverr        = s.pslverr;
    assign ad_channel     = s.channel;
    assign ad_busy        = s.busy;
    assign ad_sample_hold = s.third[acs_pkg::SH_BIT];
    assign ad_bits10      = s.second[acs_pkg::BITS10_BIT];
    assign ad_ref_connect = s.second[acs_pkg::REF_CONN_BIT];
    assign int_request    = s.pending;

    // Converter clocks seen in the running conversion, for the length check
    logic [6:0] phi_seen;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phi_seen <= 7'h00;
        end
        else if (!s.busy || done)
        begin
            phi_seen <= 7'h00;
        end
        else if (phi_en)
        begin
            phi_seen <= phi_seen + 7'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_first;
    assign wr_first = wr_fire && (paddr == acs_pkg::OFS_CONTROL_FIRST);

    AST_CHANNEL_MAP: assert property (s.busy |-> !(s.channel[3] && s.channel[2])
        && ($past(s.busy) || (s.channel[3] == s.third[acs_pkg::GROUP_BIT]
        && s.channel[1:0] == s.first[acs_pkg::CH_LSB +: 2])))
        else $error("channel out of legal range");
    AST_WRITE_UNDEF: assert property (wr_first && s.busy |=> s.undef)
        else $error("mid-conversion write not flagged undefined");
    AST_REPEAT_RUN: assert property (done && s.first[acs_pkg::MODE_BIT] && !wr_first
        |=> s.busy && s.phi_cnt == 6'd0)
        else $error("repeat mode did not restart");
    AST_SW_START: assert property (wr_first && !s.busy && pwdata[acs_pkg::START_BIT]
        && !pwdata[acs_pkg::TRIG_SEL_BIT] && sel[4] && s.third[acs_pkg::GROUP_BIT] == 1'b0
        |=> s.busy)
        else $error("software start ignored");
    AST_HW_WAIT: assert property (!s.busy && s.first[acs_pkg::TRIG_SEL_BIT] && !trig
        && !wr_fire |=> !s.busy)
        else $error("timer mode started without trigger");
    AST_REPEAT_NO_REQ: assert property (s.first[acs_pkg::MODE_BIT] && !s.pending
        && !wr_fire |=> !s.pending)
        else $error("repeat mode raised a request");
    AST_RESULT: assert property (done |=> s.result == $past(conv_data))
        else $error("result not captured");
    AST_LENGTH: assert property (done |-> phi_seen == {1'b0, target - 6'd1})
        else $error("conversion length wrong");
    AST_ONESHOT_END: assert property (done && !s.first[acs_pkg::MODE_BIT]
        && !s.first[acs_pkg::TRIG_SEL_BIT] && !wr_fire
        |=> !s.busy && s.pending && !s.first[acs_pkg::START_BIT])
        else $error("one-shot completion wrong");
    AST_ABORT: assert property (wr_first && s.busy && !pwdata[acs_pkg::START_BIT]
        |=> !s.busy ##1 !s.busy)
        else $error("abort did not stop conversion");
    AST_START_READ: assert property (s.busy |-> s.first[acs_pkg::START_BIT])
        else $error("start bit low while converting");

    // Bus answer, start refusal, timer rearm, flag clears and counter bounds; a stuck counter would hang the bus user
    AST_APB_WAIT: assert property (acc && !s.pready
        |=> s.pready && s.pslverr == !$past(hit))
        else $error("bus answer late or error flag wrong");
    AST_PROHIBITED: assert property (wr_first && !s.busy && pwdata[acs_pkg::START_BIT]
        && s.third[acs_pkg::GROUP_BIT] && !pwdata[acs_pkg::CH_MSB]
        |=> !s.busy && !s.first[acs_pkg::START_BIT])
        else $error("prohibited channel pair started");
    AST_TIMER_REARM: assert property (done && !s.first[acs_pkg::MODE_BIT]
        && s.first[acs_pkg::TRIG_SEL_BIT] && !trig && !wr_fire
        |=> !s.busy && s.first[acs_pkg::START_BIT] && s.pending)
        else $error("timer one-shot not rearmed");
    AST_PEND_CLEAR: assert property (wr_fire && paddr == acs_pkg::OFS_INT_CONTROL
        && !pwdata[acs_pkg::PEND_BIT] && !done |=> !s.pending)
        else $error("request flag not cleared");
    AST_UNDEF_CLEAR: assert property ($rose(s.busy) |-> !s.undef)
        else $error("undefined flag kept over a new start");
    AST_IDLE_QUIET: assert property (!s.busy |-> s.phi_cnt == 6'd0)
        else $error("converter count left running while idle");
    AST_PHI_BOUND: assert property (s.busy |-> s.phi_cnt < target)
        else $error("converter count past conversion length");

    COV_ONESHOT: cover property (done && !s.first[acs_pkg::MODE_BIT]);
    COV_REPEAT: cover property (done && s.first[acs_pkg::MODE_BIT] ##1 s.busy);
    COV_HW_TRIG: cover property (!s.busy && s.first[acs_pkg::TRIG_SEL_BIT] && trig ##1 s.busy);
    COV_ABORT: cover property (wr_first && s.busy && !pwdata[acs_pkg::START_BIT]);
    COV_DIVIDE: cover property (done && s.first[acs_pkg::DIV_MSB:acs_pkg::DIV_LSB] != 2'h0);

endmodule

// ===== design/acs_pkg.sv
// Constants, field layout and state type of the converter sequencer.
// Assumes one 125 MHz APB clock; the analog front-end sits outside.
package acs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL_FIRST  = 8'h00;
    localparam logic [7:0] OFS_CONTROL_SECOND = 8'h04;
    localparam logic [7:0] OFS_CONTROL_THIRD  = 8'h08;
    localparam logic [7:0] OFS_RESULT         = 8'h0C;
    localparam logic [7:0] OFS_INT_CONTROL    = 8'h10;

    // Control first fields
    localparam int CH_LSB       = 0;
    localparam int CH_MSB       = 2;
    localparam int MODE_BIT     = 3;
    localparam int TRIG_SEL_BIT = 4;
    localparam int START_BIT    = 5;
    localparam int DIV_LSB      = 6;
    localparam int DIV_MSB      = 7;

    // Control second and third fields
    localparam int BITS10_BIT   = 0;
    localparam int REF_CONN_BIT = 1;
    localparam int SH_BIT       = 0;
    localparam int GROUP_BIT    = 1;

    // Interrupt control fields
    localparam int PEND_BIT     = 0;
    localparam int UNDEF_BIT    = 1;

    // Reset values
    localparam logic [7:0] RST_CONTROL_FIRST  = 8'h00;
    localparam logic [7:0] RST_CONTROL_SECOND = 8'h00;
    localparam logic [7:0] RST_CONTROL_THIRD  = 8'h00;
    localparam logic [9:0] RST_RESULT         = 10'h000;

    // Conversion lengths in converter clocks
    localparam logic [5:0] CYC_PLAIN_8  = 6'd49;
    localparam logic [5:0] CYC_PLAIN_10 = 6'd59;
    localparam logic [5:0] CYC_SH_8     = 6'd28;
    localparam logic [5:0] CYC_SH_10    = 6'd33;

    typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_type;

endpackage

// ===== verif/acs_frontend_model.sv
// Behavioural analog front-end and PWM timer event source for the sequencer.
// Assumes the sequencer's pclk; the bench launches timer events by task.
`timescale 1ns/1ns
module acs_frontend_model
(
    // Clock
    input  wire logic       pclk,
    // From the sequencer
    input  wire logic [3:0] ad_channel,
    input  wire logic       ad_busy,
    input  wire logic       ad_bits10,
    // To the sequencer
    output logic      [9:0] conv_data,
    output logic            pwm_match_a_zero,
    output logic            pwm_underflow_one
);
    // Outcome carries channel and resolution; inverted when idle so a late sample shows
    assign conv_data = ad_busy ? {ad_channel, ad_bits10, 5'h15}
                               : ~{ad_channel, ad_bits10, 5'h15};

    // Timer events idle low
    initial
    begin
        pwm_match_a_zero  = 1'b0;
        pwm_underflow_one = 1'b0;
    end

    // One-cycle timer event, launched just after an edge
    task pulse(input logic underflow);
        @(posedge pclk);
        pwm_match_a_zero  <= !underflow;
        pwm_underflow_one <= underflow;
        @(posedge pclk);
        pwm_match_a_zero  <= 1'b0;
        pwm_underflow_one <= 1'b0;
    endtask
endmodule

// ===== verif/tb_adc_mode_trigger_sequencer.sv
// Self-checking bench for the converter sequencer over APB.
// Assumes the front-end model beside it; pclk 8 ns, reset 12 cycles.
`timescale 1ns/1ns
module tb_adc_mode_trigger_sequencer;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [9:0]  conv_data;
    logic [3:0]  ad_channel, ch_seen;
    logic        ad_busy, ad_sample_hold, ad_bits10, ad_ref_connect, int_request;
    logic        match, uflow;
    int          failures = 0;
    int          tests_run = 0;
    int          n;

    acs_sequencer acs_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_match_a_zero(match),
        .pwm_underflow_one(uflow), .conv_data(conv_data), .ad_channel(ad_channel),
        .ad_busy(ad_busy), .ad_sample_hold(ad_sample_hold), .ad_bits10(ad_bits10),
        .ad_ref_connect(ad_ref_connect), .int_request(int_request));
    acs_frontend_model acs_frontend_model_i (.pclk(pclk), .ad_channel(ad_channel),
        .ad_busy(ad_busy), .ad_bits10(ad_bits10), .conv_data(conv_data),
        .pwm_match_a_zero(match), .pwm_underflow_one(uflow));

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task conclude;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; a dead slave is caught by the watchdog
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Edges from the launching write until busy falls; channel seen first cycle
    task busy_len;
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
            if (n == 1)
                ch_seen = ad_channel;
        end while (ad_busy === 1'b1 && n < 200);
    endtask

    task t_reset;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rdat, 32'h0);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, acs_pkg::OFS_CONTROL_SECOND, 32'h2);
        repeat (125) @(posedge pclk);
        chk(32'(ad_ref_connect), 32'h1);
    endtask

    task t_oneshot(input logic [7:0] third, input logic [2:0] code, input logic b10,
                   input logic [3:0] ch, input int cyc);
        apb(1'b1, acs_pkg::OFS_CONTROL_SECOND, {31'h0, b10});
        apb(1'b1, acs_pkg::OFS_CONTROL_THIRD, 32'(third));
        apb(1'b1, acs_pkg::OFS_CONTROL_FIRST, 32'h20 | 32'(code));
        busy_len();
        chk(32'(n), 32'(cyc));
        chk(32'(ch_seen), 32'(ch));
        chk(32'(int_request), 32'h1);
        apb(1'b0, acs_pkg::OFS_CONTROL_FIRST, 32'h0);
        chk(rdat, 32'(code));
        apb(1'b0, acs_pkg::OFS_RESULT, 32'h0);
        chk(rdat, 32'({ch, b10, 5'h15}));
        apb(1'b1, acs_pkg::OFS_INT_CONTROL, 32'h0);
        apb(1'b0, acs_pkg::OFS_INT_CONTROL, 32'h0);
        chk(rdat, 32'h0);
    endtask

    // Divide-by-four converter clock; free-running divider may shorten the first tick
    task t_divide;
        apb(1'b1, acs_pkg::OFS_CONTROL_SECOND, 32'h0);
        apb(1'b1, acs_pkg::OFS_CONTROL_THIRD, 32'h1);
        apb(1'b1, acs_pkg::OFS_CONTROL_FIRST, 32'hA1);
        busy_len();
        chk(32'(n >= 109 && n <= 112), 32'h1);
        chk(32'(ch_seen), 32'h1);
        apb(1'b0, acs_pkg::OFS_CONTROL_FIRST, 32'h0);
        chk(rdat, 32'h81);
        apb(1'b1, acs_pkg::OFS_INT_CONTROL, 32'h0);
    endtask

    task t_forbidden;
        apb(1'b1, acs_pkg::OFS_CONTROL_THIRD, 32'h2);
        apb(1'b1, acs_pkg::OFS_CONTROL_FIRST, 32'h22);
        apb(1'b0, acs_pkg::OFS_CONTROL_FIRST, 32'h0);
        chk(rdat, 32'h02);
        chk(32'(ad_busy), 32'h0);
    endtask

    task t_repeat;
        apb(1'b1, acs_pkg::OFS_CONTROL_SECOND, 32'h0);
        apb(1'b1, acs_pkg::OFS_CONTROL_THIRD, 32'h0);
        apb(1'b1, acs_pkg::OFS_CONTROL_FIRST, 32'h2B);
        repeat (130) @(posedge pclk);
        #1;
        chk(32'(ad_busy), 32'h1);
        chk(32'(int_request), 32'h0);
        apb(1'b0, acs_pkg::OFS_CONTROL_FIRST, 32'h0);
        chk(rdat, 32'h2B);
        apb(1'b0, acs_pkg::OFS_RESULT, 32'h0);
        chk(rdat, 32'h0D5);
        apb(1'b1, acs_pkg::OFS_CONTROL_FIRST, 32'h0B);
        repeat (2) @(posedge pclk);
        #1;
        chk(32'(ad_busy), 32'h0);
        apb(1'b0, acs_pkg::OFS_INT_CONTROL, 32'h0);
        chk(rdat, 32'h2);
    endtask

    task t_timer;
        apb(1'b1, acs_pkg::OFS_CONTROL_FIRST, 32'h33);
        repeat (20) @(posedge pclk);
        #1;
        chk(32'(ad_busy), 32'h0);
        acs_frontend_model_i.pulse(1'b0);
        busy_len();
        chk(32'(n), 32'd49);
        apb(1'b0, acs_pkg::OFS_CONTROL_FIRST, 32'h0);
        chk(rdat, 32'h33);
        apb(1'b1, acs_pkg::OFS_INT_CONTROL, 32'h0);
        acs_frontend_model_i.pulse(1'b1);
        apb(1'b1, acs_pkg::OFS_CONTROL_FIRST, 32'h33);
        apb(1'b0, acs_pkg::OFS_INT_CONTROL, 32'h0);
        chk(rdat, 32'h2);
        busy_len();
        chk(32'(int_request), 32'h1);
        apb(1'b1, acs_pkg::OFS_CONTROL_FIRST, 32'h0);
    endtask

    // Watchdog sized well above the run, which takes under a thousand cycles
    initial
    begin
        #(8 * 30000);
        failures++;
        conclude();
    end

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_oneshot(8'h00, 3'h5, 1'b0, 4'h5, 49);
        t_oneshot(8'h03, 3'h4, 1'b0, 4'h8, 28);
        t_oneshot(8'h00, 3'h0, 1'b1, 4'h0, 59);
        t_oneshot(8'h03, 3'h7, 1'b1, 4'hB, 33);
        t_divide();
        t_forbidden();
        t_repeat();
        t_timer();
        conclude();
    end
endmodule
